// ===== design/spiodc_map.svh
// Register offsets, field positions, reset values and frame counts
`ifndef SPIODC_MAP_SVH
`define SPIODC_MAP_SVH
`define SPIODC_ADDR_FULL_RESET 7'h00
`define SPIODC_ADDR_HANDSHAKE 7'h01
`define SPIODC_ADDR_RESET_EN 7'h02
`define SPIODC_ADDR_RESULT_HI 7'h1A
`define SPIODC_ADDR_RESULT_MID 7'h1B
`define SPIODC_ADDR_RESULT_LO 7'h1C
`define SPIODC_FULL_RESET_KEY 8'hC3
`define SPIODC_SEL_MSB 3
`define SPIODC_SEL_LSB 1
`define SPIODC_TIMING_BIT 0
`define SPIODC_RESET_EN_BIT 0
`define SPIODC_SEL_RST 3'h0
`define SPIODC_TIMING_RST 1'h0
`define SPIODC_RESET_EN_RST 1'h0
`define SPIODC_INSTR_LAST_EDGE 6'h07
`define SPIODC_WRITE_LAST_EDGE 6'h0F
`define SPIODC_FRAME_1BYTE 6'h10
`define SPIODC_FRAME_2BYTE 6'h18
`define SPIODC_FRAME_3BYTE 6'h20
`define SPIODC_TX_INDEX_BASE 6'h1F
`define SPIODC_EDGE_MAX 6'h3F
`endif

// ===== design/spiodc_pkg.sv
// Types shared by the serial output drive and reset control block
`default_nettype none
package spiodc_pkg;
   typedef enum logic [2:0] {
      SPIODC_SRC_READY_SEL = 3'b000,
      SPIODC_SRC_READY_ALWAYS = 3'b011,
      SPIODC_SRC_RESULT_ONLY = 3'b100
   } spiodc_src_t;
   typedef enum logic [1:0] {
      SPIODC_DRV_FLOAT = 2'b00,
      SPIODC_DRV_DATA = 2'b01,
      SPIODC_DRV_READY = 2'b10
   } spiodc_drv_t;
endpackage : spiodc_pkg
`default_nettype wire

// ===== design/spiodc_xing_if.sv
// Signals crossing between the serial clock side and the core clock side
`timescale 1ns/1ns
`default_nettype none
interface spiodc_xing_if;
   logic reset_tgl;
   logic taken_tgl;
   logic reset_en;
   logic [23:0] result_hold;
   logic ready_n;
   modport link (output reset_tgl, output taken_tgl, output reset_en,
      input result_hold, input ready_n);
   modport core (input reset_tgl, input taken_tgl, input reset_en,
      output result_hold, output ready_n);
endinterface : spiodc_xing_if
`default_nettype wire

// ===== design/spiodc_xing.sv
// Core clock side: synchronisers, result holding and the ready flag
`timescale 1ns/1ns
`default_nettype none
module spiodc_xing import spiodc_pkg::*; (
   input wire logic clk, // Core clock
   input wire logic rst_b, // Async reset, active low
   input wire logic chip_select_n, // Chip select pin
   input wire logic [23:0] adc_result, // New conversion result
   input wire logic adc_result_valid, // Result strobe, one cycle
   output logic full_reset_pulse, // Register and conversion reset
   output logic spi_reset_enable, // Serial reset enable level
   spiodc_xing_if.core xif // Crossing to the serial side
);
   logic [1:0] cs_sync;
   logic [1:0] en_sync;
   logic [2:0] rst_sync;
   logic [2:0] taken_sync;
   logic [23:0] pend;
   logic pend_vld;
   logic reset_evt;
   logic taken_evt;
   logic deselected;

   assign reset_evt = rst_sync[2] ^ rst_sync[1];
   assign taken_evt = taken_sync[2] ^ taken_sync[1];
   assign deselected = cs_sync[1];
   assign spi_reset_enable = en_sync[1];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_sync <= 2'h3;
         en_sync <= 2'h0;
         rst_sync <= 3'h0;
         taken_sync <= 3'h0;
      end else begin
         cs_sync <= {cs_sync[0], chip_select_n};
         en_sync <= {en_sync[0], xif.reset_en};
         rst_sync <= {rst_sync[1:0], xif.reset_tgl};
         taken_sync <= {taken_sync[1:0], xif.taken_tgl};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         full_reset_pulse <= 1'b0;
      end else begin
         full_reset_pulse <= reset_evt;
      end
   end

   // Results arriving mid-frame wait, so the held word never moves under a read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 24'h00_0000;
         pend_vld <= 1'b0;
      end else if (adc_result_valid) begin
         pend <= adc_result;
         pend_vld <= 1'b1;
      end else if (deselected || reset_evt) begin
         pend_vld <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xif.result_hold <= 24'h00_0000;
      end else if (pend_vld && deselected && !reset_evt) begin
         xif.result_hold <= pend;
      end
   end

   // A fresh result wins over a read clear in the same cycle; a full reset clear wins over both
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xif.ready_n <= 1'b1;
      end else if (pend_vld && deselected && !reset_evt) begin
         xif.ready_n <= 1'b0;
      end else if (taken_evt || reset_evt) begin
         xif.ready_n <= 1'b1;
      end
   end
endmodule : spiodc_xing
`default_nettype wire

// ===== design/spiodc_top.sv
// Serial output pin drive selection and serial reset enable registers
`timescale 1ns/1ns
`default_nettype none
`include "spiodc_map.svh"
module spiodc_top import spiodc_pkg::*; (
   input wire logic clk, // Core clock, 250 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic sclk, // Serial clock from the host
   input wire logic chip_select_n, // Chip select, active low
   input wire logic sdi, // Serial data in
   output logic sdo_out, // Shared data and ready pin value
   output logic sdo_oe, // Shared pin output enable
   input wire logic [23:0] adc_result, // Conversion result word
   input wire logic adc_result_valid, // Result strobe, one cycle
   output logic full_reset_pulse, // Register and conversion reset
   output logic spi_reset_enable // Serial reset enable, core side
);
   spiodc_xing_if xif ();

   logic frame_rst_b;
   logic [5:0] edge_cnt;
   logic [6:0] shift_in;
   logic [7:0] rx_byte;
   logic instr_read;
   logic [6:0] instr_addr;
   logic rd_now;
   logic [6:0] addr_now;
   logic instr_edge;
   logic wr_now;
   logic final_rise;
   logic full_rst_hit;
   logic [2:0] output_pin_source_select;
   logic output_release_timing;
   logic reset_enable;
   logic reset_lock;
   logic reset_tgl;
   logic taken_tgl;
   logic [23:0] tx_word;
   logic rd_phase;
   logic late_drive;
   logic sdo_bit;
   logic data_drive;
   logic conversion_ready_flag_n;
   spiodc_drv_t drv;

   function automatic logic is_result(input logic [6:0] addr);
      is_result = (addr == `SPIODC_ADDR_RESULT_HI) || (addr == `SPIODC_ADDR_RESULT_MID)
         || (addr == `SPIODC_ADDR_RESULT_LO);
   endfunction : is_result

   function automatic logic [5:0] frame_bits(input logic rd, input logic [6:0] addr);
      frame_bits = `SPIODC_FRAME_1BYTE;
      if (rd && addr == `SPIODC_ADDR_RESULT_HI) begin
         frame_bits = `SPIODC_FRAME_3BYTE;
      end else if (rd && addr == `SPIODC_ADDR_RESULT_MID) begin
         frame_bits = `SPIODC_FRAME_2BYTE;
      end
   endfunction : frame_bits

   function automatic logic [23:0] read_word(input logic [6:0] addr,
      input logic [23:0] res, input logic [2:0] sel, input logic tim, input logic en);
      read_word = 24'h00_0000;
      if (addr == `SPIODC_ADDR_RESULT_HI) begin
         read_word = res;
      end else if (addr == `SPIODC_ADDR_RESULT_MID) begin
         read_word = {res[15:0], 8'h00};
      end else if (addr == `SPIODC_ADDR_RESULT_LO) begin
         read_word = {res[7:0], 16'h0000};
      end else if (addr == `SPIODC_ADDR_HANDSHAKE) begin
         read_word = {4'h0, sel, tim, 16'h0000};
      end else if (addr == `SPIODC_ADDR_RESET_EN) begin
         read_word = {7'h00, en, 16'h0000};
      end
   endfunction : read_word

   // Deselect ends the frame even while sclk is parked
   assign frame_rst_b = rst_b & ~chip_select_n;
   assign rx_byte = {shift_in, sdi};
   assign rd_now = shift_in[6];
   assign addr_now = {shift_in[5:0], sdi};
   assign instr_edge = (edge_cnt == `SPIODC_INSTR_LAST_EDGE);
   assign wr_now = !instr_read && (edge_cnt == `SPIODC_WRITE_LAST_EDGE);
   assign final_rise = (edge_cnt == frame_bits(instr_read, instr_addr) - 6'h01);
   assign full_rst_hit = wr_now && (instr_addr == `SPIODC_ADDR_FULL_RESET)
      && (rx_byte == `SPIODC_FULL_RESET_KEY);

   assign xif.reset_tgl = reset_tgl;
   assign xif.taken_tgl = taken_tgl;
   assign xif.reset_en = reset_enable;
   assign conversion_ready_flag_n = xif.ready_n;

   spiodc_xing spiodc_xing_inst (
      .clk(clk),
      .rst_b(rst_b),
      .chip_select_n(chip_select_n),
      .adc_result(adc_result),
      .adc_result_valid(adc_result_valid),
      .full_reset_pulse(full_reset_pulse),
      .spi_reset_enable(spi_reset_enable),
      .xif(xif.core)
   );

   // Frame engine on rising sclk
   always_ff @(posedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         edge_cnt <= 6'h00;
         shift_in <= 7'h00;
         instr_read <= 1'b0;
         instr_addr <= 7'h00;
      end else begin
         shift_in <= rx_byte[6:0];
         if (edge_cnt != `SPIODC_EDGE_MAX) begin
            edge_cnt <= edge_cnt + 6'h01;
         end
         if (instr_edge) begin
            instr_read <= rd_now;
            instr_addr <= addr_now;
         end
      end
   end

   always_ff @(posedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         rd_phase <= 1'b0;
         tx_word <= 24'h00_0000;
      end else if (instr_edge && rd_now) begin
         rd_phase <= 1'b1;
         tx_word <= read_word(addr_now, xif.result_hold, output_pin_source_select,
            output_release_timing, reset_enable);
      end else if (final_rise) begin
         rd_phase <= 1'b0;
      end
   end

   // Data changes on falling sclk; late_drive trails rd_phase by half a bit
   always_ff @(negedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         late_drive <= 1'b0;
         sdo_bit <= 1'b0;
      end else begin
         late_drive <= rd_phase;
         if (rd_phase) begin
            sdo_bit <= tx_word[5'(`SPIODC_TX_INDEX_BASE - edge_cnt)];
         end
      end
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         taken_tgl <= 1'b0;
      end else if (final_rise && instr_read && is_result(instr_addr)) begin
         taken_tgl <= ~taken_tgl;
      end
   end

   // Handshake control register
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         output_pin_source_select <= `SPIODC_SEL_RST;
         output_release_timing <= `SPIODC_TIMING_RST;
      end else if (full_rst_hit) begin
         output_pin_source_select <= `SPIODC_SEL_RST;
         output_release_timing <= `SPIODC_TIMING_RST;
      end else if (wr_now && instr_addr == `SPIODC_ADDR_HANDSHAKE) begin
         output_pin_source_select <= rx_byte[`SPIODC_SEL_MSB:`SPIODC_SEL_LSB];
         output_release_timing <= rx_byte[`SPIODC_TIMING_BIT];
      end
   end

   // Sticky reset enable; only a full reset or rst_b reopens it
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         reset_enable <= `SPIODC_RESET_EN_RST;
         reset_lock <= 1'b0;
      end else if (full_rst_hit) begin
         reset_enable <= `SPIODC_RESET_EN_RST;
         reset_lock <= 1'b0;
      end else if (wr_now && instr_addr == `SPIODC_ADDR_RESET_EN && !reset_lock) begin
         reset_enable <= rx_byte[`SPIODC_RESET_EN_BIT];
         reset_lock <= 1'b1;
      end
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         reset_tgl <= 1'b0;
      end else if (full_rst_hit) begin
         reset_tgl <= ~reset_tgl;
      end
   end

   // Release point picked by the timing bit
   assign data_drive = output_release_timing ? late_drive : (rd_phase & late_drive);

   // Undefined codes fall back to the default behaviour
   always_comb begin
      if (data_drive) begin
         drv = SPIODC_DRV_DATA;
      end else if (chip_select_n) begin
         drv = (output_pin_source_select == SPIODC_SRC_READY_ALWAYS)
            ? SPIODC_DRV_READY : SPIODC_DRV_FLOAT;
      end else if (output_pin_source_select == SPIODC_SRC_RESULT_ONLY) begin
         drv = SPIODC_DRV_FLOAT;
      end else begin
         drv = SPIODC_DRV_READY;
      end
   end

   always_comb begin
      sdo_oe = (drv != SPIODC_DRV_FLOAT);
      sdo_out = 1'b0;
      if (drv == SPIODC_DRV_DATA) begin
         sdo_out = sdo_bit;
      end else if (drv == SPIODC_DRV_READY) begin
         sdo_out = conversion_ready_flag_n;
      end
   end

   a_src_deselect_ready: assert property (
      @(posedge clk) disable iff (!rst_b)
      (chip_select_n && output_pin_source_select == SPIODC_SRC_READY_ALWAYS)
      |-> (sdo_oe && sdo_out == conversion_ready_flag_n))
      else $error("ready flag not driven while deselected");

   a_src_deselect_float: assert property (
      @(posedge clk) disable iff (!rst_b)
      (chip_select_n && output_pin_source_select != SPIODC_SRC_READY_ALWAYS) |-> !sdo_oe)
      else $error("pin driven while deselected");

   a_src_result_only: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!chip_select_n && !data_drive
      && output_pin_source_select == SPIODC_SRC_RESULT_ONLY) |-> !sdo_oe)
      else $error("pin driven outside a data read");

   a_release_early: assert property (
      @(negedge sclk) disable iff (!frame_rst_b)
      ($fell(rd_phase) && !output_release_timing) |-> (drv != SPIODC_DRV_DATA))
      else $error("data still driven after last rising edge");

   a_release_late_hold: assert property (
      @(negedge sclk) disable iff (!frame_rst_b)
      ($fell(rd_phase) && output_release_timing) |-> (drv == SPIODC_DRV_DATA))
      else $error("last bit released before falling edge");

   // Watched on the core clock, since sclk parks once the frame is over
   a_release_late_end: assert property (
      @(posedge clk) disable iff (!rst_b)
      ($fell(late_drive) && output_release_timing && !chip_select_n
      && output_pin_source_select == SPIODC_SRC_RESULT_ONLY) |-> !sdo_oe)
      else $error("data driven past the falling edge");

   a_rsten_first_write: assert property (
      @(posedge sclk) disable iff (!rst_b)
      (wr_now && instr_addr == `SPIODC_ADDR_RESET_EN && !reset_lock && !full_rst_hit)
      |=> (reset_lock && reset_enable == $past(sdi)))
      else $error("first reset enable write not stored");

   a_rsten_locked: assert property (
      @(posedge sclk) disable iff (!rst_b)
      (reset_lock && !full_rst_hit) |=> ($stable(reset_enable) && reset_lock))
      else $error("locked reset enable changed");

   a_full_reset_clear: assert property (
      @(posedge sclk) disable iff (!rst_b)
      full_rst_hit |=> (!reset_lock && !reset_enable
      && output_pin_source_select == `SPIODC_SEL_RST && $changed(reset_tgl)))
      else $error("full reset did not clear registers");

   a_key_only: assert property (
      @(posedge sclk) disable iff (!rst_b)
      (wr_now && instr_addr == `SPIODC_ADDR_FULL_RESET
      && rx_byte != `SPIODC_FULL_RESET_KEY) |=> $stable(reset_tgl))
      else $error("full reset taken on a wrong key");

   c_result_read: cover property (
      @(negedge sclk) disable iff (!frame_rst_b)
      $fell(rd_phase) && instr_addr == `SPIODC_ADDR_RESULT_HI);

   c_late_release: cover property (
      @(negedge sclk) disable iff (!frame_rst_b)
      $fell(rd_phase) && output_release_timing);

   c_full_reset: cover property (
      @(posedge sclk) disable iff (!rst_b) full_rst_hit && reset_lock);

   c_lock_refused: cover property (
      @(posedge sclk) disable iff (!rst_b)
      wr_now && instr_addr == `SPIODC_ADDR_RESET_EN && reset_lock);
endmodule : spiodc_top
`default_nettype wire

// ===== sim/spiodc_host_model.sv
// Serial host model: frames, bit shifting and pin observation
`timescale 1ns/1ns
`default_nettype none
module spiodc_host_model (
   output logic sclk, // Serial clock, idle low
   output logic chip_select_n, // Chip select, active low
   output logic sdi, // Serial data to the device
   input wire logic sdo_out, // Shared pin value
   input wire logic sdo_oe // Shared pin enable
);
   logic drv_last;
   logic pin;
   logic sel_oe;
   logic sel_out;
   logic tail_oe;
   logic tail_out;
   logic post_oe;
   // A floating pin must not look like the last driven bit
   always @(sdo_out or sdo_oe) begin
      if (sdo_oe === 1'b1) begin
         drv_last = sdo_out;
      end
   end
   assign pin = (sdo_oe === 1'b1) ? sdo_out : ~drv_last;
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      sdi = 1'b0;
      drv_last = 1'b0;
   end
   task automatic frame(input logic [7:0] instr, input logic [7:0] wdata, input int nbits,
      output logic [23:0] rdata);
      logic [31:0] sh;
      int i;
      sh = {instr, wdata, 16'h0000};
      rdata = 24'h00_0000;
      #1 chip_select_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         sdi = sh[31 - i];
         #80;
         if (i == 0) begin
            sel_oe = sdo_oe;
            sel_out = sdo_out;
         end
         if (i >= 8) begin
            rdata = {rdata[22:0], pin};
         end
         sclk = 1'b1;
         #20;
         if (i == nbits - 1) begin
            tail_oe = sdo_oe;
            tail_out = sdo_out;
         end
         #60 sclk = 1'b0;
      end
      #20 post_oe = sdo_oe;
      #60 chip_select_n = 1'b1;
      sdi = ~sdi;
      #80;
   endtask : frame
endmodule : spiodc_host_model
`default_nettype wire

// ===== sim/spiodc_top_test.sv
// Self-checking bench for the output drive and reset enable registers
`timescale 1ns/1ns
`default_nettype none
module spiodc_top_test;
   import spiodc_pkg::*;
   localparam int LIMIT = 60000;
   logic clk;
   logic rst_b;
   logic sclk;
   logic chip_select_n;
   logic sdi;
   logic sdo_out;
   logic sdo_oe;
   logic [23:0] adc_result;
   logic adc_result_valid;
   logic full_reset_pulse;
   logic spi_reset_enable;
   int fails;
   int compares;
   int cycles;
   int pulses;
   logic [23:0] d;

   spiodc_top spiodc_top_inst (.clk(clk), .rst_b(rst_b), .sclk(sclk),
      .chip_select_n(chip_select_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .adc_result(adc_result), .adc_result_valid(adc_result_valid),
      .full_reset_pulse(full_reset_pulse), .spi_reset_enable(spi_reset_enable));
   spiodc_host_model spiodc_host_model_inst (.sclk(sclk), .chip_select_n(chip_select_n),
      .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic test_done;
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   // Ends a hung run through the same closing report
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (full_reset_pulse === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (cycles == LIMIT) begin
         fails = fails + 1;
         $display("mismatch at %0t: run did not finish", $time);
         test_done();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [23:0] unused;
      spiodc_host_model_inst.frame({1'b0, addr}, data, 16, unused);
   endtask : wr

   task automatic rd(input logic [6:0] addr, input int nbits, output logic [23:0] r);
      spiodc_host_model_inst.frame({1'b1, addr}, 8'h00, nbits, r);
   endtask : rd

   task automatic t_reset;
      rd(7'h01, 16, d);
      chk(d, 24'h00_0000);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0000);
      rd(7'h05, 16, d);
      chk(d, 24'h00_0000);
      chk(spi_reset_enable, 1'b0);
      chk(sdo_oe, 1'b0);
   endtask : t_reset

   task automatic t_sources;
      logic [2:0] codes [3];
      int k;
      codes = '{3'h0, 3'h3, 3'h4};
      @(posedge clk);
      adc_result <= 24'hA5_5A3C;
      adc_result_valid <= 1'b1;
      @(posedge clk);
      adc_result_valid <= 1'b0;
      repeat (10) @(posedge clk);
      for (k = 0; k < 3; k++) begin
         // Reserved upper bits written as ones must read back zero
         wr(7'h01, {4'hF, codes[k], 1'b0});
         rd(7'h01, 16, d);
         chk(d, {20'h0_0000, codes[k], 1'b0});
         chk(spiodc_host_model_inst.sel_oe, codes[k] != 3'h4);
         chk(sdo_oe, codes[k] == 3'h3);
      end
      wr(7'h01, 8'h06);
      chk(sdo_out, 1'b0);
      rd(7'h1A, 32, d);
      chk(d, 24'hA5_5A3C);
      chk(sdo_oe, 1'b1);
      chk(sdo_out, 1'b1);
   endtask : t_sources

   task automatic t_release;
      wr(7'h01, 8'h08);
      rd(7'h01, 16, d);
      chk(d, 24'h00_0008);
      chk(spiodc_host_model_inst.tail_oe, 1'b0);
      rd(7'h1B, 24, d);
      chk(d, 24'h00_5A3C);
      chk(spiodc_host_model_inst.tail_oe, 1'b0);
      rd(7'h1C, 16, d);
      chk(d, 24'h00_003C);
      chk(spiodc_host_model_inst.tail_oe, 1'b0);
      wr(7'h01, 8'h09);
      rd(7'h01, 16, d);
      chk(d, 24'h00_0009);
      chk(spiodc_host_model_inst.tail_oe, 1'b1);
      chk(spiodc_host_model_inst.tail_out, 1'b1);
      chk(spiodc_host_model_inst.post_oe, 1'b0);
      rd(7'h1A, 32, d);
      chk(d, 24'hA5_5A3C);
      chk(spiodc_host_model_inst.tail_oe, 1'b1);
      chk(spiodc_host_model_inst.tail_out, 1'b0);
      chk(spiodc_host_model_inst.post_oe, 1'b0);
   endtask : t_release

   task automatic t_lock;
      wr(7'h02, 8'h01);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0001);
      chk(spi_reset_enable, 1'b1);
      wr(7'h02, 8'h00);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0001);
   endtask : t_lock

   task automatic t_full_reset;
      int p0;
      p0 = pulses;
      wr(7'h00, 8'h3C);
      chk(pulses, p0);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0001);
      rd(7'h01, 16, d);
      chk(d, 24'h00_0009);
      wr(7'h00, 8'hC3);
      repeat (20) @(posedge clk);
      chk(pulses, p0 + 1);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0000);
      rd(7'h01, 16, d);
      chk(d, 24'h00_0000);
      chk(spi_reset_enable, 1'b0);
      wr(7'h02, 8'h01);
      rd(7'h02, 16, d);
      chk(d, 24'h00_0001);
   endtask : t_full_reset

   initial begin
      fails = 0;
      compares = 0;
      cycles = 0;
      pulses = 0;
      rst_b = 1'b0;
      adc_result = 24'h00_0000;
      adc_result_valid = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_sources();
      t_release();
      t_lock();
      t_full_reset();
      test_done();
   end
endmodule : spiodc_top_test
`default_nettype wire
